// ### dv/lsx_mem_model.sv
`timescale 1ns/1ps
module lsx_mem_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic mem_exclusive,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] mem_byte_en,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] delay,
	input wire logic gm_pass,
	output logic mem_ready,
	output logic [31:0] mem_rdata,
	output logic mem_excl_okay
);
	logic [31:0] mem [0:511];
	logic [3:0] cnt;
	// A plain always lets the bench preload words; this model is never built.
	always @(posedge clk) begin
		if (srst) begin
			mem_ready <= 1'b0;
			mem_excl_okay <= 1'b0;
			mem_rdata <= 32'h0;
			cnt <= 4'h0;
		end else if (mem_req && !mem_ready && cnt >= delay) begin
			mem_ready <= 1'b1;
			mem_excl_okay <= gm_pass;
			mem_rdata <= mem[mem_addr[10:2]];
			cnt <= 4'h0;
			if (mem_write && (!mem_exclusive || gm_pass))
				for (int b = 0; b < 4; b++)
					if (mem_byte_en[b])
						mem[mem_addr[10:2]][8*b+:8] <= mem_wdata[8*b+:8];
		end else begin
			mem_ready <= 1'b0;
			mem_excl_okay <= 1'b0;
			// Toggling outside a reply keeps a stale word from passing as data.
			mem_rdata <= ~mem_rdata;
			cnt <= (mem_req && !mem_ready) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule : lsx_mem_model

// ### dv/lsx_unit_sva.sv
`timescale 1ns/1ps
module lsx_unit_sva (
	input wire logic clk,
	input wire logic srst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire lsx_pkg::lsx_op_e cmd_op,
	input wire logic io_port_hit,
	input wire logic exception_boundary,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	input wire logic [3:0] mem_byte_en,
	input wire logic mem_ready,
	input wire logic done,
	input wire logic hard_fault_exception,
	input wire logic flags_write
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic acc, xl, xs, io_q, open_q;
	assign acc = cmd_valid && cmd_ready;
	assign xl = acc && cmd_op == lsx_pkg::exclusive_load_op;
	assign xs = acc && cmd_op == lsx_pkg::exclusive_store_op;
	always_ff @(posedge clk) begin
		if (srst)
			io_q <= 1'b0;
		else
			io_q <= (xl || xs) && io_port_hit;
	end
	// Open or closed only, as the unit keeps no address or size.
	always_ff @(posedge clk) begin
		if (srst)
			open_q <= 1'b0;
		else if (xl && !io_port_hit)
			open_q <= 1'b1;
		else if (xs || exception_boundary || (acc && cmd_op == lsx_pkg::clear_exclusive_op))
			open_q <= 1'b0;
	end
	chk_flags_quiet: assert property (flags_write == 1'b0)
		else $error("condition flags written");
	chk_io_fault: assert property (io_q |-> hard_fault_exception && !done && !mem_req)
		else $error("no fault on exclusive port access");
	chk_clear_done: assert property (acc && cmd_op == lsx_pkg::clear_exclusive_op |=> done)
		else $error("clear exclusive not done in one cycle");
	chk_closed_store: assert property (xs && !io_port_hit && !open_q |=>
		!mem_req ##1 done && !mem_req)
		else $error("closed monitor store touched memory");
	chk_req_hold: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
		else $error("request dropped or moved before ready");
	chk_multi_step: assert property (mem_req && mem_ready ##1 mem_req |->
		mem_addr == $past(mem_addr) + 32'h0000_0004)
		else $error("next beat not four bytes on");
	chk_word_lanes: assert property (mem_req && mem_write && mem_size == lsx_pkg::SIZE_WORD
		|-> mem_byte_en == 4'hF)
		else $error("word store lanes wrong");
	chk_narrow_lane: assert property (mem_req && mem_write && mem_size != lsx_pkg::SIZE_WORD
		|-> (mem_size == lsx_pkg::SIZE_BYTE && $onehot(mem_byte_en))
		|| (mem_size == lsx_pkg::SIZE_HALF && mem_byte_en inside {4'h3, 4'hC}))
		else $error("narrow store lanes wrong");
	cover property (mem_req && mem_ready ##1 mem_req);
	cover property (io_q);
	cover property (xs && !open_q);
endmodule : lsx_unit_sva
bind lsx_unit lsx_unit_sva u_lsx_unit_sva (.clk, .srst, .cmd_valid, .cmd_ready, .cmd_op,
	.io_port_hit, .exception_boundary, .mem_req, .mem_write, .mem_addr, .mem_size,
	.mem_byte_en, .mem_ready, .done, .hard_fault_exception, .flags_write);

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_writeback = 1'b0, io_port_hit = 1'b0;
	logic ext_exclusive_all_bit = 1'b0, global_monitor_present = 1'b0, gm_pass = 1'b1;
	logic exception_boundary = 1'b0;
	logic default_shared = 1'b0, prot_enable = 1'b0, prot_shared = 1'b0;
	lsx_pkg::lsx_op_e cmd_op = lsx_pkg::load_word_op;
	logic [1:0] cmd_excl_size = lsx_pkg::SIZE_WORD;
	logic [2:0] cmd_data_reg = 3'h0, cmd_base_reg = 3'h0, dbg_reg_sel = 3'h0;
	logic [7:0] cmd_reg_list = 8'h00, cmd_imm = 8'h00;
	logic [31:0] pc = 32'h0000_0100;
	logic [3:0] delay = 4'h0;
	logic cmd_ready, mem_req, mem_write, mem_exclusive, mem_ready, mem_excl_okay, done;
	logic hard_fault_exception, got_fault;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, dbg_reg_data, target_addr;
	logic [1:0] mem_size;
	logic [3:0] mem_byte_en;
	int num_errors = 0;
	int comparisons = 0;
	lsx_pkg::lsx_op_e lops [5] = '{lsx_pkg::load_word_op, lsx_pkg::load_byte_zext_op,
		lsx_pkg::load_half_zext_op, lsx_pkg::load_byte_sext_op, lsx_pkg::load_half_sext_op};
	logic [31:0] lexp [5] = '{32'h8081_F2E3, 32'h0000_00E3, 32'h0000_F2E3, 32'hFFFF_FFE3,
		32'hFFFF_F2E3};
	lsx_pkg::lsx_op_e sops [3] = '{lsx_pkg::store_word_op, lsx_pkg::store_byte_op,
		lsx_pkg::store_half_op};
	logic [31:0] sexp [3] = '{32'h1234_5672, 32'hAAAA_AA72, 32'hAAAA_5672};
	lsx_unit u_lsx_unit (.clk, .srst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_excl_size,
		.cmd_data_reg, .cmd_base_reg, .cmd_offset_reg(3'h1), .cmd_status_reg(3'h5), .cmd_reg_list,
		.cmd_writeback, .cmd_imm, .pc, .target_addr, .io_port_hit, .default_shared,
		.prot_enable, .prot_shared, .ext_exclusive_all_bit, .global_monitor_present,
		.exception_boundary, .mem_req, .mem_write, .mem_exclusive, .mem_addr, .mem_size,
		.mem_byte_en, .mem_wdata, .mem_ready, .mem_rdata, .mem_excl_okay, .done,
		.hard_fault_exception, .flags_write(), .dbg_reg_sel, .dbg_reg_data);
	lsx_mem_model u_lsx_mem_model (.clk, .srst, .mem_req, .mem_write, .mem_exclusive,
		.mem_addr, .mem_byte_en, .mem_wdata, .delay, .gm_pass, .mem_ready, .mem_rdata,
		.mem_excl_okay);
	initial begin
		forever #10 clk = ~clk;
	end
	task finish_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// aligned multiple base
	// The base register is R0 unless a scenario picks another, and every base stays aligned.
	task issue(input lsx_pkg::lsx_op_e op, input logic [2:0] d, input logic [7:0] lst,
		input logic [7:0] imm, input logic [1:0] sz = lsx_pkg::SIZE_WORD);
		int n;
		n = 0;
		@(posedge clk);
		cmd_op <= op;
		cmd_data_reg <= d;
		cmd_reg_list <= lst;
		cmd_imm <= imm;
		cmd_excl_size <= sz;
		cmd_valid <= 1'b1;
		do begin @(negedge clk); n++; end while (cmd_ready !== 1'b1 && n < 300);
		@(posedge clk);
		cmd_valid <= 1'b0;
		do begin @(negedge clk); n++; end
		while (done !== 1'b1 && hard_fault_exception !== 1'b1 && n < 300);
		got_fault = hard_fault_exception;
		if (n >= 300) begin
			num_errors++;
			finish_test();
		end
	endtask : issue
	task chk_reg(input logic [2:0] r, input logic [31:0] exp);
		@(posedge clk);
		dbg_reg_sel <= r;
		@(posedge clk);
		@(negedge clk);
		chk("register", dbg_reg_data, exp);
	endtask : chk_reg
	task t_ldm;
		issue(lsx_pkg::load_multi_incr_after, 3'h0, 8'hFF, 8'h00);
		for (int i = 0; i < 8; i++)
			chk_reg(3'(i), i == 0 ? 32'h40 : i == 1 ? 32'h4 : 32'h1234_5670 + i);
		chk_reg(3'h0, 32'h0000_0040);
	endtask : t_ldm
	task t_loads;
		for (int k = 0; k < 5; k++) begin
			issue(lops[k], 3'h7, 8'h00, 8'h00);
			chk_reg(3'h7, lexp[k]);
			chk("offset addr", target_addr, 32'h0000_0044);
		end
	endtask : t_loads
	task t_stores;
		for (int k = 0; k < 3; k++) begin
			u_lsx_mem_model.mem[17] = 32'hAAAA_AAAA;
			issue(sops[k], 3'h2, 8'h00, 8'h00);
			chk("store", u_lsx_mem_model.mem[17], sexp[k]);
		end
	endtask : t_stores
	task t_pcrel;
		issue(lsx_pkg::load_pc_rel_op, 3'h6, 8'h00, 8'hFF);
		chk_reg(3'h6, 32'h5A5A_0FF0);
		chk("pc target", target_addr, 32'h0000_04FC);
	endtask : t_pcrel
	task xs(input logic [1:0] sz, input int ev, input logic [31:0] st);
		u_lsx_mem_model.mem[16] = 32'h0;
		// same address pairing
		// The size differs from the store only where the open-only monitor is exercised.
		if (ev != 3)
			issue(lsx_pkg::exclusive_load_op, 3'h6, 8'h00, 8'h00, sz);
		if (ev == 1)
			issue(lsx_pkg::clear_exclusive_op, 3'h0, 8'h00, 8'h00);
		if (ev == 2) begin
			@(posedge clk);
			exception_boundary <= 1'b1;
			@(posedge clk);
			exception_boundary <= 1'b0;
		end
		issue(lsx_pkg::exclusive_store_op, 3'h2, 8'h00, 8'h00);
		chk_reg(3'h5, st);
		chk("excl mem", u_lsx_mem_model.mem[16], st == 0 ? 32'h1234_5672 : 32'h0);
	endtask : xs
	task t_excl;
		xs(lsx_pkg::SIZE_WORD, 0, lsx_pkg::STATUS_PASS);
		xs(lsx_pkg::SIZE_WORD, 3, lsx_pkg::STATUS_FAIL);
		xs(lsx_pkg::SIZE_WORD, 1, lsx_pkg::STATUS_FAIL);
		xs(lsx_pkg::SIZE_WORD, 2, lsx_pkg::STATUS_FAIL);
		xs(lsx_pkg::SIZE_BYTE, 0, lsx_pkg::STATUS_PASS);
		@(posedge clk);
		ext_exclusive_all_bit <= 1'b1;
		xs(lsx_pkg::SIZE_WORD, 0, lsx_pkg::STATUS_FAIL);
		@(posedge clk);
		global_monitor_present <= 1'b1;
		gm_pass <= 1'b0;
		xs(lsx_pkg::SIZE_WORD, 0, lsx_pkg::STATUS_FAIL);
		@(posedge clk);
		gm_pass <= 1'b1;
		xs(lsx_pkg::SIZE_WORD, 0, lsx_pkg::STATUS_PASS);
		@(posedge clk);
		ext_exclusive_all_bit <= 1'b0;
	endtask : t_excl
	task t_fault;
		@(posedge clk);
		io_port_hit <= 1'b1;
		issue(lsx_pkg::exclusive_load_op, 3'h6, 8'h00, 8'h00);
		chk("fault", {31'h0, got_fault}, 32'h1);
		issue(lsx_pkg::exclusive_store_op, 3'h2, 8'h00, 8'h00);
		chk("fault", {31'h0, got_fault}, 32'h1);
		@(posedge clk);
		io_port_hit <= 1'b0;
	endtask : t_fault
	task t_shared;
		@(posedge clk);
		global_monitor_present <= 1'b0;
		default_shared <= 1'b1;
		xs(lsx_pkg::SIZE_WORD, 0, lsx_pkg::STATUS_FAIL);
		issue(lsx_pkg::load_pc_rel_op, 3'h7, 8'h00, 8'h00);
		chk_reg(3'h7, 32'hC000_0040);
		@(posedge clk);
		cmd_base_reg <= 3'h7;
		xs(lsx_pkg::SIZE_WORD, 0, lsx_pkg::STATUS_PASS);
		@(posedge clk);
		prot_enable <= 1'b1;
		prot_shared <= 1'b1;
		xs(lsx_pkg::SIZE_WORD, 0, lsx_pkg::STATUS_FAIL);
		@(posedge clk);
		cmd_base_reg <= 3'h0;
		prot_shared <= 1'b0;
		xs(lsx_pkg::SIZE_WORD, 0, lsx_pkg::STATUS_PASS);
		@(posedge clk);
		prot_enable <= 1'b0;
		default_shared <= 1'b0;
	endtask : t_shared
	task t_multi_wb;
		@(posedge clk);
		cmd_writeback <= 1'b1;
		delay <= 4'h3;
		issue(lsx_pkg::store_multi_incr_after, 3'h0, 8'h0C, 8'h00);
		chk("stm lo", u_lsx_mem_model.mem[16], 32'h1234_5672);
		chk("stm hi", u_lsx_mem_model.mem[17], 32'h1234_5673);
		chk_reg(3'h0, 32'h0000_0048);
		issue(lsx_pkg::load_multi_incr_after, 3'h0, 8'h30, 8'h00);
		chk_reg(3'h4, 32'h1234_5682);
		chk_reg(3'h5, 32'h1234_5683);
		chk_reg(3'h0, 32'h0000_0050);
	endtask : t_multi_wb
	initial begin
		for (int i = 0; i < 512; i++)
			u_lsx_mem_model.mem[i] = 32'h1234_5670 + i;
		u_lsx_mem_model.mem[0] = 32'h0000_0040;
		u_lsx_mem_model.mem[1] = 32'h0000_0004;
		u_lsx_mem_model.mem[17] = 32'h8081_F2E3;
		u_lsx_mem_model.mem[319] = 32'h5A5A_0FF0;
		u_lsx_mem_model.mem[64] = 32'hC000_0040;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		t_ldm();
		t_loads();
		t_stores();
		t_pcrel();
		t_excl();
		t_fault();
		t_shared();
		t_multi_wb();
		finish_test();
	end
endmodule : testbench

// ### include/lsx_mon_if.sv
`timescale 1ns/1ps
interface lsx_mon_if;
	logic open_req;
	logic close_req;
	logic [31:0] addr;
	logic ext_all;
	logic prot_enable;
	logic prot_shared;
	logic default_shared;
	logic is_open;
	logic use_global;

	modport mon (
		input open_req,
		input close_req,
		input addr,
		input ext_all,
		input prot_enable,
		input prot_shared,
		input default_shared,
		output is_open,
		output use_global
	);
	modport core (
		output open_req,
		output close_req,
		output addr,
		output ext_all,
		output prot_enable,
		output prot_shared,
		output default_shared,
		input is_open,
		input use_global
	);
endinterface : lsx_mon_if

// ### include/lsx_pkg.sv
package lsx_pkg;
	typedef enum logic [3:0] {
		load_word_op,
		load_byte_zext_op,
		load_half_zext_op,
		load_byte_sext_op,
		load_half_sext_op,
		store_word_op,
		store_byte_op,
		store_half_op,
		load_pc_rel_op,
		load_multi_incr_after,
		store_multi_incr_after,
		exclusive_load_op,
		exclusive_store_op,
		clear_exclusive_op
	} lsx_op_e;

	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [31:0] STATUS_PASS = 32'h0000_0000;
	localparam logic [31:0] STATUS_FAIL = 32'h0000_0001;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;
	localparam logic [31:0] DEV_LO0 = 32'h0400_0000;
	localparam logic [31:0] DEV_HI0 = 32'h5FFF_FFFF;
	localparam logic [31:0] DEV_LO1 = 32'hC000_0000;
	localparam logic [31:0] DEV_HI1 = 32'hFFFF_FFFF;
	localparam int NUM_REGS = 8;
	localparam int REG_IDX_W = 3;
	localparam int PC_IMM_W = 8;
endpackage : lsx_pkg

// ### rtl/lsx_monitor.sv
`timescale 1ns/1ps
module lsx_monitor (
	input wire logic clk,
	input wire logic srst,
	lsx_mon_if.mon mon
);
	logic open_state;
	logic in_dev_range;

	// open flag only
	// Only open or closed is kept; address and size are deliberately not tagged.
	always_ff @(posedge clk) begin
		if (srst) begin
			open_state <= 1'b0;
		end else if (mon.open_req) begin
			open_state <= 1'b1;
		end else if (mon.close_req) begin
			open_state <= 1'b0;
		end
	end

	always_comb begin
		in_dev_range = ((mon.addr >= lsx_pkg::DEV_LO0) && (mon.addr <= lsx_pkg::DEV_HI0)) ||
			((mon.addr >= lsx_pkg::DEV_LO1) && (mon.addr <= lsx_pkg::DEV_HI1));
	end

	assign mon.is_open = open_state;
	assign mon.use_global = mon.ext_all ||
		(mon.prot_enable ? mon.prot_shared : (mon.default_shared && !in_dev_range));
endmodule : lsx_monitor

// ### rtl/lsx_unit.sv
// How it works
// - Register-offset loads write word, zero- or sign-extended byte or halfword.
// - Register-offset stores write whole word, low byte or low halfword only.
// - Register-offset address is base register plus offset register.
// - No operation here ever modifies the condition flags.
// - PC-relative load fetches one aligned word within 1020 bytes of PC.
// - Multiple transfers use consecutive words from base, four bytes apart.
// - Multiple transfers go in increasing register order, lowest register lowest address.
// - Writeback sets base to original base plus four times register count, except on a load whose list holds the base.
// - Exclusive store writes status 0 when stored, 1 when not stored.
// - Local monitor holds only open or closed, no address or size.
// - Exclusive access to the I/O port space raises a hard fault.
// - Global monitor also used for shared default-map or shared protected targets.
// - Default-map device ranges skip the global monitor when extension bit clear.
// - Extended-exclusive-all bit routes every exclusive access to the global monitor.
// - Exclusive store needing an absent global monitor always fails.
// - Exception boundary closes the local monitor, so the next store fails.
// - Clear-exclusive makes the next exclusive store fail unless reopened.
`timescale 1ns/1ps
module lsx_unit (
	input wire logic clk,
	input wire logic srst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire lsx_pkg::lsx_op_e cmd_op,
	input wire logic [1:0] cmd_excl_size,
	input wire logic [lsx_pkg::REG_IDX_W-1:0] cmd_data_reg,
	input wire logic [lsx_pkg::REG_IDX_W-1:0] cmd_base_reg,
	input wire logic [lsx_pkg::REG_IDX_W-1:0] cmd_offset_reg,
	input wire logic [lsx_pkg::REG_IDX_W-1:0] cmd_status_reg,
	input wire logic [lsx_pkg::NUM_REGS-1:0] cmd_reg_list,
	input wire logic cmd_writeback,
	input wire logic [lsx_pkg::PC_IMM_W-1:0] cmd_imm,
	input wire logic [31:0] pc,
	output logic [31:0] target_addr,
	input wire logic io_port_hit,
	input wire logic default_shared,
	input wire logic prot_enable,
	input wire logic prot_shared,
	input wire logic ext_exclusive_all_bit,
	input wire logic global_monitor_present,
	input wire logic exception_boundary,
	output logic mem_req,
	output logic mem_write,
	output logic mem_exclusive,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic [3:0] mem_byte_en,
	output logic [31:0] mem_wdata,
	input wire logic mem_ready,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_excl_okay,
	output logic done,
	output logic hard_fault_exception,
	output logic flags_write,
	input wire logic [lsx_pkg::REG_IDX_W-1:0] dbg_reg_sel,
	output logic [31:0] dbg_reg_data
);
	typedef enum logic [1:0] {st_idle, st_mem, st_done} lsx_state_e;

	lsx_state_e state;
	logic [31:0] regs [lsx_pkg::NUM_REGS];
	lsx_pkg::lsx_op_e op;
	logic [1:0] size;
	logic sext;
	logic [lsx_pkg::REG_IDX_W-1:0] data_reg, base_reg, status_reg;
	logic [lsx_pkg::NUM_REGS-1:0] list_left;
	logic [lsx_pkg::NUM_REGS-1:0] list_all;
	logic writeback;
	logic [31:0] addr, base_start, status_val;
	logic use_global_q;
	logic [lsx_pkg::REG_IDX_W-1:0] cur_reg;
	logic is_multi, is_load, accept;
	logic [1:0] next_size;
	logic excl_fail;

	lsx_mon_if mon_bus ();

	lsx_monitor u_monitor (
		.clk(clk),
		.srst(srst),
		.mon(mon_bus.core)
	);

	function automatic logic [lsx_pkg::REG_IDX_W-1:0] lowest_set(
		input logic [lsx_pkg::NUM_REGS-1:0] mask);
		logic [lsx_pkg::REG_IDX_W-1:0] idx;
		idx = '0;
		for (int i = lsx_pkg::NUM_REGS - 1; i >= 0; i--) begin
			if (mask[i]) begin
				idx = lsx_pkg::REG_IDX_W'(i);
			end
		end
		return idx;
	endfunction : lowest_set

	function automatic logic [3:0] count_set(input logic [lsx_pkg::NUM_REGS-1:0] mask);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < lsx_pkg::NUM_REGS; i++) begin
			n = n + {3'h0, mask[i]};
		end
		return n;
	endfunction : count_set

	function automatic logic [1:0] op_size(input lsx_pkg::lsx_op_e o, input logic [1:0] xs);
		case (o)
			lsx_pkg::load_byte_zext_op, lsx_pkg::load_byte_sext_op,
			lsx_pkg::store_byte_op: return lsx_pkg::SIZE_BYTE;
			lsx_pkg::load_half_zext_op, lsx_pkg::load_half_sext_op,
			lsx_pkg::store_half_op: return lsx_pkg::SIZE_HALF;
			lsx_pkg::exclusive_load_op, lsx_pkg::exclusive_store_op: return xs;
			default: return lsx_pkg::SIZE_WORD;
		endcase
	endfunction : op_size

	// The word-sized exclusive forms take a scaled offset; byte and halfword forms do not.
	always_comb begin
		next_size = op_size(cmd_op, cmd_excl_size);
		case (cmd_op)
			lsx_pkg::load_pc_rel_op: target_addr = (pc & lsx_pkg::WORD_ALIGN_MASK) +
				({24'h0, cmd_imm} << 2);
			lsx_pkg::load_multi_incr_after, lsx_pkg::store_multi_incr_after:
				target_addr = regs[cmd_base_reg];
			lsx_pkg::exclusive_load_op, lsx_pkg::exclusive_store_op:
				target_addr = (next_size == lsx_pkg::SIZE_WORD) ?
					regs[cmd_base_reg] + ({24'h0, cmd_imm} << 2) : regs[cmd_base_reg];
			default: target_addr = regs[cmd_base_reg] + regs[cmd_offset_reg];
		endcase
	end

	assign cmd_ready = (state == st_idle);
	assign accept = cmd_valid && cmd_ready;
	assign is_multi = (op == lsx_pkg::load_multi_incr_after) ||
		(op == lsx_pkg::store_multi_incr_after);
	assign is_load = !(op == lsx_pkg::store_word_op || op == lsx_pkg::store_byte_op ||
		op == lsx_pkg::store_half_op || op == lsx_pkg::store_multi_incr_after ||
		op == lsx_pkg::exclusive_store_op);
	assign cur_reg = is_multi ? lowest_set(list_left) : data_reg;

	assign excl_fail = !mon_bus.is_open || (mon_bus.use_global && !global_monitor_present);

	assign mon_bus.addr = target_addr;
	assign mon_bus.ext_all = ext_exclusive_all_bit;
	assign mon_bus.prot_enable = prot_enable;
	assign mon_bus.prot_shared = prot_shared;
	assign mon_bus.default_shared = default_shared;
	assign mon_bus.open_req = accept && (cmd_op == lsx_pkg::exclusive_load_op) && !io_port_hit;
	// exception clears monitor
	// Every exclusive store consumes the monitor, pass or fail.
	assign mon_bus.close_req = exception_boundary ||
		(accept && (cmd_op == lsx_pkg::clear_exclusive_op)) ||
		(accept && (cmd_op == lsx_pkg::exclusive_store_op));

	assign flags_write = 1'b0;

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= st_idle;
			op <= lsx_pkg::load_word_op;
			size <= lsx_pkg::SIZE_WORD;
			sext <= 1'b0;
			data_reg <= '0;
			base_reg <= '0;
			status_reg <= '0;
			list_left <= '0;
			list_all <= '0;
			writeback <= 1'b0;
			addr <= '0;
			base_start <= '0;
			status_val <= lsx_pkg::STATUS_PASS;
			use_global_q <= 1'b0;
			hard_fault_exception <= 1'b0;
			done <= 1'b0;
		end else begin
			hard_fault_exception <= 1'b0;
			done <= 1'b0;
			case (state)
				st_idle: begin
					if (accept) begin
						op <= cmd_op;
						size <= next_size;
						sext <= (cmd_op == lsx_pkg::load_byte_sext_op) ||
							(cmd_op == lsx_pkg::load_half_sext_op);
						data_reg <= cmd_data_reg;
						base_reg <= cmd_base_reg;
						status_reg <= cmd_status_reg;
						list_left <= cmd_reg_list;
						list_all <= cmd_reg_list;
						writeback <= cmd_writeback;
						addr <= target_addr;
						base_start <= regs[cmd_base_reg];
						use_global_q <= mon_bus.use_global;
						status_val <= lsx_pkg::STATUS_PASS;
						if ((cmd_op == lsx_pkg::exclusive_load_op ||
							cmd_op == lsx_pkg::exclusive_store_op) && io_port_hit) begin
							hard_fault_exception <= 1'b1;
						end else if (cmd_op == lsx_pkg::clear_exclusive_op) begin
							done <= 1'b1;
						end else if (cmd_op == lsx_pkg::exclusive_store_op && excl_fail) begin
							status_val <= lsx_pkg::STATUS_FAIL;
							state <= st_done;
						end else if ((cmd_op == lsx_pkg::load_multi_incr_after ||
							cmd_op == lsx_pkg::store_multi_incr_after) && cmd_reg_list == '0) begin
							state <= st_done;
						end else begin
							state <= st_mem;
						end
					end
				end
				st_mem: begin
					if (mem_ready) begin
						if (op == lsx_pkg::exclusive_store_op && use_global_q && !mem_excl_okay) begin
							status_val <= lsx_pkg::STATUS_FAIL;
						end
						if (is_multi) begin
							addr <= addr + lsx_pkg::WORD_BYTES;
							list_left[cur_reg] <= 1'b0;
							if ((list_left & ~(lsx_pkg::NUM_REGS'(1) << cur_reg)) == '0) begin
								state <= st_done;
							end
						end else begin
							state <= st_done;
						end
					end
				end
				st_done: begin
					done <= 1'b1;
					state <= st_idle;
				end
				default: state <= st_idle;
			endcase
		end
	end

	// Memory request held steady until the far side accepts it.
	always_comb begin
		mem_req = (state == st_mem);
		mem_write = !is_load;
		mem_exclusive = (op == lsx_pkg::exclusive_load_op) || (op == lsx_pkg::exclusive_store_op);
		mem_addr = addr;
		mem_size = size;
		case (size)
			lsx_pkg::SIZE_BYTE: mem_byte_en = 4'h1 << addr[1:0];
			lsx_pkg::SIZE_HALF: mem_byte_en = addr[1] ? 4'hC : 4'h3;
			default: mem_byte_en = 4'hF;
		endcase
		mem_wdata = regs[cur_reg] << {addr[1:0], 3'h0};
	end

	logic [31:0] lane_data, load_val;
	always_comb begin
		lane_data = mem_rdata >> {addr[1:0], 3'h0};
		case (size)
			lsx_pkg::SIZE_BYTE: load_val = {{24{sext && lane_data[7]}}, lane_data[7:0]};
			lsx_pkg::SIZE_HALF: load_val = {{16{sext && lane_data[15]}}, lane_data[15:0]};
			default: load_val = lane_data;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < lsx_pkg::NUM_REGS; i++) begin
				regs[i] <= '0;
			end
		end else if (state == st_mem && mem_ready && is_load) begin
			regs[cur_reg] <= load_val;
		end else if (state == st_done) begin
			if (op == lsx_pkg::exclusive_store_op) begin
				regs[status_reg] <= status_val;
			end else if (is_multi && writeback && !(is_load && list_all[base_reg])) begin
				regs[base_reg] <= base_start + ({28'h0, count_set(list_all)} << 2);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dbg_reg_data <= '0;
		end else begin
			dbg_reg_data <= regs[dbg_reg_sel];
		end
	end
endmodule : lsx_unit
